// >>> include/tcp_pkg.sv
// Package for the channel enable and polarity slice of the advanced timer.
// Assumes a single AHB-Lite master and 32-bit word access only.
package tcp_pkg;

    localparam int          NUM_CH         = 4;        // Capture/compare channels
    localparam int          NUM_COMPL      = 3;        // Channels with a complementary pin
    localparam int          CLK_HZ         = 40000000; // Kernel clock rate

    // Register byte offsets
    localparam logic [11:0] ADDR_ENPOL     = 12'h000;  // channel_enable_polarity_reg
    localparam logic [11:0] ADDR_CONFIG    = 12'h004;  // Preload, lock, mode controls
    localparam logic [11:0] ADDR_STATUS    = 12'h008;  // Live pin and input state

    // Reset values
    localparam logic [15:0] ENPOL_RESET    = 16'h0000;
    localparam logic [7:0]  CONFIG_RESET   = 8'h00;

    // Field positions inside channel_enable_polarity_reg
    localparam int          CH_FIELD_W     = 4;        // Bits per channel slice
    localparam int          POS_OUT_EN     = 0;        // Main output enable
    localparam int          POS_POL        = 1;        // Main polarity
    localparam int          POS_COMPL_EN   = 2;        // Complementary output enable
    localparam int          POS_COMPL_POL  = 3;        // Complementary polarity
    localparam logic [15:0] ENPOL_WMASK    = 16'h3FFF; // Bits 15:14 reserved

    // Field positions inside the configuration register
    localparam int          POS_PRELOAD    = 0;
    localparam int          POS_LOCK_LO    = 1;
    localparam int          POS_MODE_LO    = 3;
    localparam int          POS_ENCODER    = 7;

    // Lock levels that freeze the complementary polarity bits
    localparam logic [1:0]  LOCK_LEVEL_2   = 2'h2;
    localparam logic [1:0]  LOCK_LEVEL_3   = 2'h3;

    // Input polarity pair encodings {compl_polarity, main_polarity}
    localparam logic [1:0]  PAIR_RISE      = 2'h0;
    localparam logic [1:0]  PAIR_FALL      = 2'h1;
    localparam logic [1:0]  PAIR_BOTH      = 2'h3;

    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        TCP_BUS_IDLE   = 2'b01,
        TCP_BUS_RDWAIT = 2'b10
    } tcp_bus_e;

    // Configuration register fields
    typedef struct packed {
        logic                encoder_mode;            // Encoder interface active
        logic [NUM_CH-1:0]   ch_input_mode;           // 1 = channel is an input
        logic [1:0]          lock_level;              // Protection level
        logic                control_bits_preload_en; // Preload on commutation
    } tcp_config_s;

    // Latched AHB address phase
    typedef struct packed {
        logic                valid;
        logic                write;
        logic [11:0]         addr;
    } tcp_addr_phase_s;

endpackage

// >>> hw/tcp_channel_enpol.sv
// Channel output enable and polarity control slice with AHB-Lite registers.
// Assumes reference signals from compare logic and filtered channel inputs
// that are already synchronous to hclk; commutation arrives as a pulse.
//
// Functional notes
// - Main polarity 0 active high, 1 low
// - Input pair 00 rising, 01 inverted falling
// - Pair 11 both edges, not in encoder
// - Bit 2 enables channel 1 complementary output
// - Bit 3 sets complementary active level
// - Input mode: complementary bit joins edge selection
// - Preloaded complementary polarity applies on commutation
// - Lock level 2 or 3 freezes complementary polarity
// - Channel 2 fields in bits 4 to 7
// - Channel 3 fields in bits 8 to 11
// - Channel 4 only enable and polarity
// - Bits 15 to 14 read zero
module tcp_channel_enpol
    import tcp_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,      // Total channels
    parameter int COMPLS   = NUM_COMPL    // Channels with complementary pin
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic [CHANNELS-1:0]   channel_ref,
    input  wire logic [CHANNELS-1:0]   filtered_channel_input,
    input  wire logic                  commutation_event,
    output logic [CHANNELS-1:0]        main_pin,
    output logic [COMPLS-1:0]          complementary_pin,
    output logic [CHANNELS-1:0]        polarized_input,
    output logic [CHANNELS-1:0]        capture_edge
);

    // The register layout fixes four channels, three complementary
    initial begin
        if (CHANNELS != NUM_CH || COMPLS != NUM_COMPL) begin
            $error("tcp_channel_enpol: only 4 channels with 3 complementary are served");
        end
    end

    // Storage overview:
    // - enpol is what software wrote, masked to the used bits
    // - compl_pol_act is the complementary level the pins use
    // - cfg holds preload, lock level, input modes and encoder flag
    // - input_prev keeps one sample of history for edge detection
    // The read of the enable register returns enpol, not the bits
    // in force, so software sees a preloaded value before the
    // commutation pulse applies it. The status word shows the level in force.
    // Nothing here is a counter; every register is a plain level.

    // Register state
    logic [15:0]            enpol;          // Software view of the enable/polarity reg
    logic [COMPLS-1:0]      compl_pol_act;  // Complementary polarity in force
    tcp_config_s            cfg;            // Preload, lock and mode controls
    logic [CHANNELS-1:0]    input_prev;     // Filtered inputs one cycle ago

    // Bus state
    tcp_bus_e               bus_state;
    tcp_addr_phase_s        aph;            // Address phase held for data phase

    // Write strobes decoded from the latched address phase
    logic                   wr_enpol;
    logic                   wr_config;
    logic                   locked;
    logic [15:0]            enpol_wdata;

    // Read mux shared by the data phase
    function automatic logic [31:0] read_mux(input logic [11:0] a,
                                             input logic [15:0] ep,
                                             input tcp_config_s c,
                                             input logic [15:0] st);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == ADDR_ENPOL) begin
            r = {16'h0000, ep & ENPOL_WMASK};
        end else if (a == ADDR_CONFIG) begin
            r = {24'h00_0000, c};
        end else if (a == ADDR_STATUS) begin
            r = {16'h0000, st};
        end
        return r;
    endfunction

    // Address phase accepted only when the bus is ready
    wire accept = hsel & hready & (htrans == HTRANS_NONSEQ);

    // Bus timing summary:
    // - write: address edge, then data edge lands the register
    // - read: address edge drops hreadyout for one cycle
    // - read: next edge loads hrdata and raises hreadyout
    // The read wait costs a cycle but lets a write that ends on the
    // same edge as a read address phase show up in the read data.
    // hsize is ignored; part-word writes are not served.
    // A write to an unmapped offset is taken and dropped, OKAY.
    // Any stray state code falls back to idle with the bus ready.

    // Bus sequencing: writes without wait, reads take one wait state so
    // a write just before them is already in the registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= TCP_BUS_IDLE;
            aph       <= '0;
            hreadyout <= 1'b1;
        end else begin
            case (bus_state)
                TCP_BUS_IDLE: begin
                    if (accept) begin
                        aph <= '{valid: 1'b1, write: hwrite, addr: haddr[11:0]};
                        if (!hwrite) begin
                            // Insert the wait for the read
                            bus_state <= TCP_BUS_RDWAIT;
                            hreadyout <= 1'b0;
                        end
                    end else begin
                        aph.valid <= 1'b0;
                    end
                end
                TCP_BUS_RDWAIT: begin
                    // Data latched this edge, release the bus
                    bus_state <= TCP_BUS_IDLE;
                    hreadyout <= 1'b1;
                    aph.valid <= 1'b0;
                end
                default: begin
                    bus_state <= TCP_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Read data captured at the end of the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state == TCP_BUS_RDWAIT) begin
            hrdata <= read_mux(aph.addr, enpol, cfg,
                               {1'b0, compl_pol_act, 1'b0, complementary_pin,
                                main_pin, polarized_input});
        end
    end

    // Write strobes come from the latched address phase, so they
    // line up with hwdata in the data phase.
    // Lock level 2 or 3 freezes only the complementary polarity
    // bits; enables and main polarity stay writable.
    // The lock level itself stays writable, so software can drop
    // the protection again; a stronger scheme would need a
    // write-once latch, which this slice does not model.

    // Write decode; only whole words are expected, so hsize is not checked
    assign wr_enpol  = aph.valid & aph.write & (aph.addr == ADDR_ENPOL);
    assign wr_config = aph.valid & aph.write & (aph.addr == ADDR_CONFIG);
    assign locked    = (cfg.lock_level == LOCK_LEVEL_2) |
                       (cfg.lock_level == LOCK_LEVEL_3);

    // Merge write data, keeping frozen complementary polarity bits
    always_comb begin
        enpol_wdata = hwdata[15:0] & ENPOL_WMASK;
        for (int c = 0; c < COMPLS; c++) begin
            if (locked) begin
                // Locked writes leave the old value standing
                enpol_wdata[c*CH_FIELD_W+POS_COMPL_POL] =
                    enpol[c*CH_FIELD_W+POS_COMPL_POL];
            end
        end
    end

    // Software view of channel fields: channels 1-3 take four bits each,
    // channel 4 only two, the top two are reserved
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enpol <= ENPOL_RESET;
        end else if (wr_enpol) begin
            enpol <= enpol_wdata;
        end
    end

    // Configuration register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= CONFIG_RESET;
        end else if (wr_config) begin
            cfg <= hwdata[7:0];
        end
    end

    // Preload handling:
    // - preload off: level follows the register on every write
    // - preload on: level copies the register at the pulse only
    // Several writes between two pulses collapse into the last
    // one; only the value standing at the pulse is applied.
    // A locked write keeps the old bit in enpol, so a later pulse
    // cannot sneak a refused value in through the preload path.
    // Main polarity and enables have no preload; they act at once.
    // Channel 4 has no complementary bit and is not in this loop.

    // Complementary polarity in force: immediate, or held until the
    // commutation event when preload is on
    generate
        for (genvar c = 0; c < COMPLS; c++) begin : g_compl_pol
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    compl_pol_act[c] <= ENPOL_RESET[c*CH_FIELD_W+POS_COMPL_POL];
                end else if (cfg.control_bits_preload_en) begin
                    if (commutation_event) begin
                        // Picks up any value written before the event
                        compl_pol_act[c] <= enpol[c*CH_FIELD_W+POS_COMPL_POL];
                    end
                end else if (wr_enpol) begin
                    compl_pol_act[c] <= enpol_wdata[c*CH_FIELD_W+POS_COMPL_POL];
                end else begin
                    compl_pol_act[c] <= enpol[c*CH_FIELD_W+POS_COMPL_POL];
                end
            end
        end
    endgenerate

    // Edge detection compares this sample with the last one.
    // History resets low, the same as the partner's idle level,
    // so no false rising edge follows reset.
    // Inputs are taken as already synchronous; an asynchronous
    // source needs its own two-stage synchroniser ahead of this.
    // A pulse shorter than one clock period may be missed.

    // Edge history of the filtered inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_prev <= '0;
        end else begin
            input_prev <= filtered_channel_input;
        end
    end

    // Per channel:
    // - output mode: pin = reference xor active-low flag
    // - disabled or input: pin rests at its inactive level
    // - input mode: polarity pair picks inversion and edge
    // Pair 10 is unused and treated as rising, uninverted.
    // Pair 11 is uninverted and both-edge, except in encoder mode
    // where it falls back to rising to avoid double counting.
    // capture_edge is a one-cycle pulse, only for input channels.
    // The main pin idles at its polarity level, not at zero, so a
    // low-active driver sees its off level as soon as it is set.

    // Per-channel pins, input polarity and capture edge
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
            logic       en_main;   // Main output enable
            logic       pol_main;  // Main active level
            logic [1:0] pair;      // {compl, main} polarity pair
            logic       rise;
            logic       fall;
            logic       hit;

            assign en_main  = enpol[c*CH_FIELD_W+POS_OUT_EN];
            assign pol_main = enpol[c*CH_FIELD_W+POS_POL];
            assign rise     = filtered_channel_input[c] & ~input_prev[c];
            assign fall     = ~filtered_channel_input[c] & input_prev[c];

            if (c < COMPLS) begin : g_pair
                // Complementary bit takes part in input edge choice
                assign pair = {compl_pol_act[c], pol_main};
            end else begin : g_pair4
                // Channel 4 has no complementary bit
                assign pair = {1'b0, pol_main};
            end

            // Edge select; both edges refused in encoder mode, falls back
            // to rising so the counter never double counts
            always_comb begin
                case (pair)
                    PAIR_FALL: hit = fall;
                    PAIR_BOTH: hit = cfg.encoder_mode ? rise : (rise | fall);
                    default:   hit = rise;
                endcase
            end

            // Inverted only for the 01 pair
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    polarized_input[c] <= 1'b0;
                    capture_edge[c]    <= 1'b0;
                end else begin
                    polarized_input[c] <= filtered_channel_input[c] ^
                                          (pair == PAIR_FALL);
                    capture_edge[c]    <= cfg.ch_input_mode[c] & hit;
                end
            end

            // Main pin: reference through polarity, idle at inactive level
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    main_pin[c] <= 1'b0;
                end else if (en_main && !cfg.ch_input_mode[c]) begin
                    main_pin[c] <= channel_ref[c] ^ pol_main;
                end else begin
                    main_pin[c] <= pol_main;
                end
            end

            if (c < COMPLS) begin : g_compl
                // Complementary pin carries the inverted reference
                always_ff @(posedge hclk or negedge hresetn) begin
                    if (!hresetn) begin
                        complementary_pin[c] <= 1'b0;
                    end else if (enpol[c*CH_FIELD_W+POS_COMPL_EN] &&
                                 !cfg.ch_input_mode[c]) begin
                        complementary_pin[c] <= ~channel_ref[c] ^
                                                compl_pol_act[c];
                    end else begin
                        complementary_pin[c] <= compl_pol_act[c];
                    end
                end
            end
        end
    endgenerate

    // Latency summary for users of this slice:
    // - pins follow channel_ref one edge later
    // - pins follow a register write one edge after it lands
    // - capture_edge pulses one edge after the input change is seen
    // - preloaded complementary level moves at the pulse edge,
    //   and the complementary pin one edge after that
    // No output is combinational; all come straight from flops.
    // Reset drives every pin low regardless of polarity settings.

endmodule

// >>> testbench/tcp_channel_enpol_properties.sv
// Checker for the channel enable and polarity slice: bus timing, pin laws.
// Assumes one AHB-Lite master; shadows register writes seen on the bus.
module tcp_enpol_checker
    import tcp_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    input wire logic                hclk,
    input wire logic                hresetn,
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic                hreadyout,
    input wire logic [31:0]         hrdata,
    input wire logic                hresp,
    input wire logic [CHANNELS-1:0] channel_ref,
    input wire logic [CHANNELS-1:0] filtered_channel_input,
    input wire logic [CHANNELS-1:0] main_pin,
    input wire logic [CHANNELS-1:0] polarized_input,
    input wire logic [CHANNELS-1:0] capture_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic                wpend; // Write data phase pending
    logic [11:0]         wadr;  // Address of that write
    logic [15:0]         ep;    // Shadow of the enable register
    logic [7:0]          cfg;   // Shadow of the configuration register
    logic [CHANNELS-1:0] mexp;  // Expected main pins one edge on
    wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
    // Shadow lands on the same edge as the real register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wpend <= 1'b0;
            wadr  <= 12'h000;
            ep    <= ENPOL_RESET;
            cfg   <= CONFIG_RESET;
        end else begin
            wpend <= take && hwrite;
            wadr  <= haddr[11:0];
            if (wpend && wadr == ADDR_ENPOL) ep <= hwdata[15:0];
            if (wpend && wadr == ADDR_CONFIG) cfg <= hwdata[7:0];
        end
    end
    // Disabled or input channels rest at their polarity level
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            mexp[i] = ep[4*i+1] ^ (ep[4*i] & ~cfg[3+i] & channel_ref[i]);
        end
    end
    sequence read_wait_s;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence enpol_read_s;
        take && !hwrite && haddr[11:0] == ADDR_ENPOL;
    endsequence
    okay_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
    write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    read_wait_a: assert property (take && !hwrite |=> read_wait_s) else $error("read wait wrong");
    reserved_zero_a: assert property (enpol_read_s |=> ##1 hrdata[31:14] == 18'h0)
        else $error("reserved bits not zero");
    read_back_a: assert property (enpol_read_s |=> ##1
        (hrdata[13:0] & 14'h3777) == ($past(ep[13:0]) & 14'h3777)) else $error("read back");
    main_pin_a: assert property (main_pin == $past(mexp)) else $error("main pin");
    ch4_pol_a: assert property (polarized_input[3] == $past(filtered_channel_input[3] ^ ep[13]))
        else $error("channel 4 input polarity");
    cap_rise_a: assert property (cfg[6] && !ep[13] && $rose(filtered_channel_input[3])
        |-> ##[1:2] capture_edge[3]) else $error("rising edge missed");
    cap_fall_a: assert property (cfg[6] && !ep[13] && $fell(filtered_channel_input[3])
        |-> ##1 !capture_edge[3]) else $error("falling edge captured");
endmodule

// >>> testbench/tcp_pin_partner.sv
// Model of the external source behind the filtered channel inputs.
// Assumes the bench sets the level; a stalled source holds its old level.
module tcp_pin_partner
#(
    parameter int CHANNELS = 4
) (
    input  wire logic                hclk,
    input  wire logic [CHANNELS-1:0] src_level,
    input  wire logic                stall,
    output logic      [CHANNELS-1:0] filtered_channel_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Re-timed to hclk, so the design never sees a mid-cycle change
    initial filtered_channel_input = '0;
    always @(posedge hclk) if (!stall) filtered_channel_input <= src_level;
endmodule

// >>> testbench/timer_channel_output_enable_polarity_tb.sv
// Self-checking bench for the channel enable and polarity slice.
// Assumes the design is the only AHB-Lite slave; the partner feeds inputs.
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module timer_channel_output_enable_polarity_tb import tcp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, comm, stall, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, d;
    logic [1:0]  htrans, p;
    logic [2:0]  hsize, cpin;
    logic [3:0]  cref, src, fin, mpin, pin, cap;
    logic [15:0] ep;
    int          err_count, checked, caps, rc, seed;
    tcp_channel_enpol uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .channel_ref(cref),
        .filtered_channel_input(fin), .commutation_event(comm), .main_pin(mpin),
        .complementary_pin(cpin), .polarized_input(pin), .capture_edge(cap));
    tcp_pin_partner #(.CHANNELS(NUM_CH)) src_model (.hclk(hclk), .src_level(src),
        .stall(stall), .filtered_channel_input(fin));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Counted on the falling edge, clear of the bench's own edge traffic
    always @(negedge hclk) if (cap[0] === 1'b1) caps++;
    function automatic logic [3:0] exp_main(logic [15:0] e, logic [3:0] r);
        for (int i = 0; i < 4; i++)
            exp_main[i] = e[4*i+1] ^ (e[4*i] & r[i]);
    endfunction
    function automatic logic [2:0] exp_comp(logic [15:0] e, logic [3:0] r);
        for (int i = 0; i < 3; i++)
            exp_comp[i] = e[4*i+3] ^ (e[4*i+2] & ~r[i]);
    endfunction
    task automatic finish_test;
        $display("Checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            err_count++;
            finish_test;
        end
    endtask
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= {20'h0, a};
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dt;
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        ahb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    initial begin
        {hresetn, hsel, hwrite, comm, stall, htrans, haddr, hwdata} = '0;
        {cref, src, err_count, checked, caps} = '0;
        hsize = 3'h2;
        seed = 32'hBED1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        chk_rd(ADDR_ENPOL, 32'h0, "enpol reset");
        chk_rd(ADDR_CONFIG, 32'h0, "config reset");
        ahb(1'b1, 12'h0FC, 32'hFFFFFFFF);
        chk_rd(12'h0FC, 32'h0, "unmapped");
        // Random output setups, corner patterns first
        for (int k = 0; k < 40; k++) begin
            d = (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $random(seed);
            ep = d[15:0];
            ahb(1'b1, ADDR_ENPOL, d);
            chk_rd(ADDR_ENPOL, {18'h0, ep[13:0]}, "enpol");
            cref <= 4'($random(seed));
            stall <= 1'($random(seed));
            src <= 4'($random(seed));
            repeat (3) @(posedge hclk);
            `CHK("main", exp_main(ep, cref), mpin)
            `CHK("compl", exp_comp(ep, cref), cpin)
        end
        // Every input pair, then both edges under encoder mode
        stall <= 1'b0;
        ahb(1'b1, ADDR_CONFIG, 32'h78);
        for (int k = 0; k < 5; k++) begin
            p = (k == 4) ? 2'h3 : 2'(k);
            if (k == 4) ahb(1'b1, ADDR_CONFIG, 32'hF8);
            ahb(1'b1, ADDR_ENPOL, {28'h0, p[1], 1'b0, p[0], 1'b0});
            src <= 4'h0;
            repeat (5) @(posedge hclk);
            caps = 0;
            src <= 4'hF;
            repeat (5) @(posedge hclk);
            rc = caps;
            `CHK("in pol", 1'b1 ^ (p == PAIR_FALL), pin[0])
            caps = 0;
            src <= 4'h0;
            repeat (5) @(posedge hclk);
            `CHK("rise cap", int'(p != PAIR_FALL), rc)
            `CHK("fall cap", int'(k < 4 && p[0]), caps)
        end
        // Lock levels 2 and 3 freeze only the complementary polarity bits
        ahb(1'b1, ADDR_CONFIG, 32'h0);
        ahb(1'b1, ADDR_ENPOL, 32'h0);
        for (int lv = 2; lv < 4; lv++) begin
            ahb(1'b1, ADDR_CONFIG, 32'(lv << 1));
            ahb(1'b1, ADDR_ENPOL, 32'h0888 | 32'(lv));
            chk_rd(ADDR_ENPOL, 32'(lv), "locked");
        end
        // Preloaded polarity waits for a commutation pulse
        ahb(1'b1, ADDR_CONFIG, 32'h1);
        ahb(1'b1, ADDR_ENPOL, 32'h0008);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("held", 1'b0, rd[12])
        `CHK("held pin", 1'b0, cpin[0])
        comm <= 1'b1;
        @(posedge hclk);
        comm <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK("applied pin", 1'b1, cpin[0])
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("applied", 1'b1, rd[12])
        finish_test;
    end
endmodule
bind tcp_channel_enpol tcp_enpol_checker #(.CHANNELS(CHANNELS)) chk (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .channel_ref(channel_ref), .filtered_channel_input(filtered_channel_input),
    .main_pin(main_pin), .polarized_input(polarized_input), .capture_edge(capture_edge));
